/* src/rsc_pkg.sv */
// Package holding the constants, types and register map of the reset source and cause logic.
// Assumes a single 40 MHz clock and an APB register port with 32-bit data.
package rsc_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned POWERUP_TIMER_MS = 64;
  localparam int unsigned POWERUP_TIMER_CYC = POWERUP_TIMER_MS * (CLK_HZ / 1000);
  localparam int unsigned OST_CYC = 1024;
  localparam int unsigned START_FOSC = 10;
  localparam int unsigned FILT_NS = 100;
  localparam int unsigned FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 22;
  localparam int unsigned FILT_W = 4;
  localparam int unsigned SYNC_W = 3;

  // Register byte offsets.
  localparam logic [7:0] OFS_POWER_CONTROL_REG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_PIN = 8'h0C;

  // Program counter targets.
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] INT_VECTOR = 16'h0004;

  typedef struct packed {
    logic stack_overflow_flag;
    logic stack_underflow_flag;
    logic unused5;
    logic watchdog_reset_flag;
    logic pin_reset_flag;
    logic instruction_reset_flag;
    logic poweron_flag;
    logic brownout_flag;
  } rsc_power_control_reg_t;

  typedef struct packed {
    logic timeout_status;
    logic powerdown_status;
  } rsc_status_t;

  typedef struct packed {
    logic ost_required_cfg;
    logic stack_reset_enable_cfg;
    logic low_voltage_program_cfg;
    logic reset_pin_enable_cfg;
    logic powerup_timer_enable_cfg;
    logic low_power_brownout_cfg;
  } rsc_cfg_t;

  // Field positions.
  localparam int unsigned STATUS_TO_BIT = 4;
  localparam int unsigned STATUS_PD_BIT = 3;
  localparam int unsigned PIN_PULLUP_BIT = 0;
  localparam int unsigned PIN_LEVEL_BIT = 1;

  // Reset and event values.
  localparam rsc_power_control_reg_t POWER_CONTROL_REG_POR = 8'h1C;
  localparam rsc_status_t STATUS_POR = 2'h3;
  localparam rsc_cfg_t CFG_RESET = 6'h1C;
  localparam logic PULLUP_RESET = 1'h1;

  typedef enum logic [1:0] {
    PC_HOLD,
    PC_ZERO,
    PC_NEXT,
    PC_NEXT_VEC
  } rsc_pc_act_t;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_POWERUP_TIMER,
    ST_OST,
    ST_PIN,
    ST_DELAY,
    ST_RUN
  } rsc_state_t;

endpackage

/* src/rsc_sync.sv */
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the inputs are quasi-static levels; the reset level is given by a parameter.
module rsc_sync #(
  parameter logic [rsc_pkg::SYNC_W-1:0] RST_VAL = 3'h0
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [rsc_pkg::SYNC_W-1:0] d,
  output logic [rsc_pkg::SYNC_W-1:0] q
);

  logic [rsc_pkg::SYNC_W-1:0] meta_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* src/rsc_glitch_filter.sv */
// Pulse rejection filter for the synchronised external reset pin level.
// Assumes a synchronised input; the output moves only after the input has stood FILT_CYC cycles.
module rsc_glitch_filter (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic level_in,
  output logic level_out
);

  logic [rsc_pkg::FILT_W-1:0] cnt_q;
  logic [rsc_pkg::FILT_W-1:0] cnt_d;
  logic differs;
  logic done;

  assign differs = level_in != level_out;
  assign done = cnt_q == rsc_pkg::FILT_W'(rsc_pkg::FILT_CYC - 1);
  assign cnt_d = (!differs || done) ? '0 : cnt_q + 1'b1;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q <= '0;
      level_out <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      if (differs && done) begin
        level_out <= level_in;
      end
    end
  end

endmodule

/* src/rsc_reset_ctrl.sv */
// Reset source combiner, start-up sequencer and reset cause flags with an APB register port.
// Assumes ARST_N is the power-on reset, and event inputs are one-cycle pulses on CLK.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.

module rsc_reset_ctrl #(
  parameter int unsigned POWERUP_TIMER_CYCLES = rsc_pkg::POWERUP_TIMER_CYC
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BROWNOUT_DETECT,
  input wire logic LOW_POWER_BROWNOUT_DETECT,
  input wire logic EXTERNAL_RESET_PIN,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic WATCHDOG_WAKE,
  input wire logic INTERRUPT_WAKE,
  input wire logic CLEAR_WATCHDOG_INSTR,
  input wire logic RESET_INSTR,
  input wire logic STACK_OVERFLOW,
  input wire logic STACK_UNDERFLOW,
  input wire logic PROGRAM_MODE_EXIT,
  input wire logic SLEEPING,
  input wire logic GLOBAL_INTERRUPT_ENABLE,
  output logic DEVICE_RESET_N,
  output logic PC_LOAD,
  output logic [1:0] PC_ACTION,
  output logic [15:0] PC_TARGET,
  output logic PIN_PULLUP_EN
);

  logic [rsc_pkg::SYNC_W-1:0] async_raw;
  logic [rsc_pkg::SYNC_W-1:0] async_sync;
  logic bor_sync;
  logic low_power_brownout_detect_sync;
  logic pin_sync;
  logic pin_filt;

  rsc_pkg::rsc_power_control_reg_t power_control_reg_q;
  rsc_pkg::rsc_power_control_reg_t power_control_reg_d;
  rsc_pkg::rsc_status_t status_q;
  rsc_pkg::rsc_status_t status_d;
  rsc_pkg::rsc_cfg_t cfg_q;
  logic sw_pullup_q;
  rsc_pkg::rsc_state_t state_q;
  rsc_pkg::rsc_state_t state_d;
  logic [rsc_pkg::TMR_W-1:0] tmr_q;
  logic [rsc_pkg::TMR_W-1:0] tmr_d;
  logic power_path_q;
  logic power_path_d;

  assign async_raw = {BROWNOUT_DETECT, LOW_POWER_BROWNOUT_DETECT, EXTERNAL_RESET_PIN};

  rsc_sync #(
    .RST_VAL(3'h1)
  ) u_sync (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .d(async_raw),
    .q(async_sync)
  );

  assign bor_sync = async_sync[2];
  assign low_power_brownout_detect_sync = async_sync[1];
  assign pin_sync = async_sync[0];

  rsc_glitch_filter u_filter (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .level_in(pin_sync),
    .level_out(pin_filt)
  );

  // Reset source decoding.
  logic low_power_brownout_detect_req;
  logic gen_bor;
  logic pin_enabled;
  logic pin_rst;
  logic running;
  logic wdt_rst;
  logic instr_rst;
  logic ovf_rst;
  logic unf_rst;
  logic pin_evt;
  logic wdt_wake;
  logic int_wake;
  logic power_evt;
  logic pulse_rst;
  logic powerup_timer_done;
  logic ost_done;
  logic delay_done;

  assign low_power_brownout_detect_req = cfg_q.low_power_brownout_cfg & low_power_brownout_detect_sync;
  assign gen_bor = bor_sync | low_power_brownout_detect_req;
  assign pin_enabled = cfg_q.low_voltage_program_cfg | cfg_q.reset_pin_enable_cfg;
  assign pin_rst = pin_enabled & ~pin_filt;
  assign running = state_q == rsc_pkg::ST_RUN;
  assign wdt_rst = running & WATCHDOG_TIMEOUT & ~SLEEPING;
  assign instr_rst = running & RESET_INSTR;
  assign ovf_rst = running & STACK_OVERFLOW & cfg_q.stack_reset_enable_cfg;
  assign unf_rst = running & STACK_UNDERFLOW & cfg_q.stack_reset_enable_cfg;
  assign pin_evt = running & pin_rst;
  assign wdt_wake = running & SLEEPING & WATCHDOG_WAKE;
  assign int_wake = running & SLEEPING & INTERRUPT_WAKE & ~WATCHDOG_WAKE;
  assign power_evt = gen_bor | PROGRAM_MODE_EXIT;
  assign pulse_rst = wdt_rst | instr_rst | ovf_rst | unf_rst;
  assign powerup_timer_done = tmr_q >= rsc_pkg::TMR_W'(POWERUP_TIMER_CYCLES - 1);
  assign ost_done = tmr_q >= rsc_pkg::TMR_W'(rsc_pkg::OST_CYC - 1);
  assign delay_done = tmr_q >= rsc_pkg::TMR_W'(rsc_pkg::START_FOSC - 1);

  // Start-up sequencer.
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q + 1'b1;
    power_path_d = power_path_q;
    case (state_q)
      rsc_pkg::ST_HOLD: begin
        tmr_d = '0;
        if (!gen_bor && !pin_rst) begin
          state_d = power_path_q ? rsc_pkg::ST_POWERUP_TIMER : rsc_pkg::ST_PIN;
        end
      end
      rsc_pkg::ST_POWERUP_TIMER: begin
        if (!cfg_q.powerup_timer_enable_cfg || powerup_timer_done) begin
          state_d = rsc_pkg::ST_OST;
          tmr_d = '0;
        end
      end
      rsc_pkg::ST_OST: begin
        if (!cfg_q.ost_required_cfg || ost_done) begin
          state_d = rsc_pkg::ST_PIN;
          tmr_d = '0;
        end
      end
      rsc_pkg::ST_PIN: begin
        tmr_d = '0;
        if (!pin_rst) begin
          state_d = rsc_pkg::ST_DELAY;
        end
      end
      rsc_pkg::ST_DELAY: begin
        if (pin_rst) begin
          state_d = rsc_pkg::ST_PIN;
          tmr_d = '0;
        end else if (delay_done) begin
          state_d = rsc_pkg::ST_RUN;
          power_path_d = 1'b0;
          tmr_d = '0;
        end
      end
      rsc_pkg::ST_RUN: begin
        tmr_d = '0;
        if (pin_rst || pulse_rst) begin
          state_d = rsc_pkg::ST_HOLD;
        end
      end
      default: begin
        state_d = rsc_pkg::ST_HOLD;
        tmr_d = '0;
      end
    endcase
    if (power_evt) begin
      state_d = rsc_pkg::ST_HOLD;
      power_path_d = 1'b1;
      tmr_d = '0;
    end
  end

  // APB decoding.
  logic setup_ph;
  logic access_wr;
  logic addr_ok;
  logic wr_power_control_reg;
  logic wr_cfg;
  logic wr_pin;
  logic [31:0] rd_mux;

  assign setup_ph = PSEL & ~PENABLE;
  assign access_wr = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign addr_ok = PADDR == rsc_pkg::OFS_POWER_CONTROL_REG || PADDR == rsc_pkg::OFS_STATUS ||
                   PADDR == rsc_pkg::OFS_CFG || PADDR == rsc_pkg::OFS_PIN;
  assign wr_power_control_reg = access_wr & (PADDR == rsc_pkg::OFS_POWER_CONTROL_REG);
  assign wr_cfg = access_wr & (PADDR == rsc_pkg::OFS_CFG);
  assign wr_pin = access_wr & (PADDR == rsc_pkg::OFS_PIN);

  always_comb begin
    rd_mux = '0;
    case (PADDR)
      rsc_pkg::OFS_POWER_CONTROL_REG: rd_mux[7:0] = power_control_reg_q;
      rsc_pkg::OFS_STATUS: begin
        rd_mux[rsc_pkg::STATUS_TO_BIT] = status_q.timeout_status;
        rd_mux[rsc_pkg::STATUS_PD_BIT] = status_q.powerdown_status;
      end
      rsc_pkg::OFS_CFG: rd_mux[5:0] = cfg_q;
      rsc_pkg::OFS_PIN: begin
        rd_mux[rsc_pkg::PIN_PULLUP_BIT] = sw_pullup_q;
        rd_mux[rsc_pkg::PIN_LEVEL_BIT] = pin_sync;
      end
      default: rd_mux = '0;
    endcase
  end

  // Cause flags; a software write is applied first so a hardware event in the same cycle wins.
  always_comb begin
    power_control_reg_d = power_control_reg_q;
    status_d = status_q;
    if (wr_power_control_reg) begin
      power_control_reg_d = rsc_pkg::rsc_power_control_reg_t'(PWDATA[7:0]);
      power_control_reg_d.unused5 = 1'b0;
    end
    if (CLEAR_WATCHDOG_INSTR && running) begin
      status_d = rsc_pkg::STATUS_POR;
    end
    if (wdt_rst) begin
      power_control_reg_d.watchdog_reset_flag = 1'b0;
      status_d.timeout_status = 1'b0;
    end
    if (wdt_wake) begin
      status_d = 2'h0;
    end
    if (int_wake) begin
      status_d = 2'h2;
    end
    if (instr_rst) begin
      power_control_reg_d.instruction_reset_flag = 1'b0;
    end
    if (pin_evt) begin
      power_control_reg_d.pin_reset_flag = 1'b0;
      if (SLEEPING) begin
        status_d = 2'h2;
      end
    end
    if (ovf_rst) begin
      power_control_reg_d.stack_overflow_flag = 1'b1;
    end
    if (unf_rst) begin
      power_control_reg_d.stack_underflow_flag = 1'b1;
    end
    if (gen_bor) begin
      power_control_reg_d.stack_overflow_flag = 1'b0;
      power_control_reg_d.stack_underflow_flag = 1'b0;
      power_control_reg_d.pin_reset_flag = 1'b1;
      power_control_reg_d.instruction_reset_flag = 1'b1;
      power_control_reg_d.brownout_flag = 1'b0;
      status_d = rsc_pkg::STATUS_POR;
    end
    if (PROGRAM_MODE_EXIT) begin
      power_control_reg_d = rsc_pkg::POWER_CONTROL_REG_POR;
      status_d = rsc_pkg::STATUS_POR;
    end
  end

  // Program counter action for the core.
  logic start_run;
  rsc_pkg::rsc_pc_act_t pc_act_d;
  logic [15:0] pc_tgt_d;

  assign start_run = state_q == rsc_pkg::ST_DELAY && state_d == rsc_pkg::ST_RUN;
  assign pc_act_d = start_run ? rsc_pkg::PC_ZERO :
                    (wdt_wake || (int_wake && !GLOBAL_INTERRUPT_ENABLE)) ? rsc_pkg::PC_NEXT :
                    int_wake ? rsc_pkg::PC_NEXT_VEC : rsc_pkg::PC_HOLD;
  assign pc_tgt_d = pc_act_d == rsc_pkg::PC_NEXT_VEC ? rsc_pkg::INT_VECTOR : rsc_pkg::RESET_VECTOR;

  // Power-on reset values apply under ARST_N, and on PROGRAM_MODE_EXIT to the cause and status flags only; other causes only move individual flags.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      power_control_reg_q <= rsc_pkg::POWER_CONTROL_REG_POR;
      status_q <= rsc_pkg::STATUS_POR;
      cfg_q <= rsc_pkg::CFG_RESET;
      sw_pullup_q <= rsc_pkg::PULLUP_RESET;
    end else begin
      power_control_reg_q <= power_control_reg_d;
      status_q <= status_d;
      if (wr_cfg) begin
        cfg_q <= rsc_pkg::rsc_cfg_t'(PWDATA[5:0]);
      end
      if (wr_pin) begin
        sw_pullup_q <= PWDATA[rsc_pkg::PIN_PULLUP_BIT];
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= rsc_pkg::ST_HOLD;
      tmr_q <= '0;
      power_path_q <= 1'b1;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      power_path_q <= power_path_d;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DEVICE_RESET_N <= 1'b0;
      PC_LOAD <= 1'b0;
      PC_ACTION <= 2'h0;
      PC_TARGET <= 16'h0000;
      PIN_PULLUP_EN <= 1'b1;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      DEVICE_RESET_N <= state_d == rsc_pkg::ST_RUN;
      PC_LOAD <= pc_act_d != rsc_pkg::PC_HOLD;
      PC_ACTION <= pc_act_d;
      PC_TARGET <= pc_tgt_d;
      PIN_PULLUP_EN <= pin_enabled | sw_pullup_q;
      PREADY <= setup_ph;
      PSLVERR <= setup_ph & ~addr_ok;
      if (setup_ph) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // The pin is only ever sampled; this block drives no pin level, only the pull-up enable PIN_PULLUP_EN.

  // Counts cycles since the pin was seen released in the pin-wait or delay state.
  logic [3:0] rel_cnt_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rel_cnt_q <= 4'h0;
    end else if (power_evt || pin_rst || !(state_q == rsc_pkg::ST_PIN || state_q == rsc_pkg::ST_DELAY)) begin
      rel_cnt_q <= 4'h0;
    end else if (rel_cnt_q != 4'hF) begin
      rel_cnt_q <= rel_cnt_q + 4'h1;
    end
  end

  // Checks.
  bor_holds_reset_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    gen_bor |=> !DEVICE_RESET_N && !power_control_reg_q.brownout_flag)
    else $error("brown-out did not hold reset and clear flag");

  low_power_brownout_detect_gated_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !cfg_q.low_power_brownout_cfg && !bor_sync |-> !gen_bor)
    else $error("low-power brown-out acted while disabled");

  pin_enable_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    cfg_q.low_voltage_program_cfg |-> pin_enabled)
    else $error("reset pin not enabled under low-voltage programming");

  pin_low_holds_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    pin_rst && !running |=> !DEVICE_RESET_N)
    else $error("device left reset while pin held low");

  glitch_ignored_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(pin_filt) |-> $past(pin_sync, 1) && $past(pin_sync, 2))
    else $error("filter passed a short pulse");

  wdt_reset_flags_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    wdt_rst && !power_evt |=> !power_control_reg_q.watchdog_reset_flag && !status_q.timeout_status && !DEVICE_RESET_N)
    else $error("watchdog reset flags wrong");

  instr_flag_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    instr_rst && !power_evt |=> !power_control_reg_q.instruction_reset_flag ##1 !DEVICE_RESET_N)
    else $error("reset instruction flag not cleared");

  stack_gate_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    running && !cfg_q.stack_reset_enable_cfg && !pin_rst && !wdt_rst && !instr_rst && !power_evt |=> DEVICE_RESET_N)
    else $error("stack event reset while disabled");

  prog_exit_por_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    PROGRAM_MODE_EXIT |=> power_control_reg_q == rsc_pkg::POWER_CONTROL_REG_POR && status_q == rsc_pkg::STATUS_POR)
    else $error("programming exit not like power-on");

  start_delay_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    rel_cnt_q == 4'(rsc_pkg::START_FOSC) && !pin_rst && !power_evt |=> DEVICE_RESET_N)
    else $error("start not ten cycles after pin release");

  pc_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(DEVICE_RESET_N) |-> PC_LOAD && PC_ACTION == 2'(rsc_pkg::PC_ZERO) && PC_TARGET == 16'h0000)
    else $error("reset did not load zero vector");

  int_vector_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    int_wake && GLOBAL_INTERRUPT_ENABLE && !start_run |=> PC_TARGET == 16'h0004 && !status_q.powerdown_status)
    else $error("interrupt wake did not target vector");

endmodule

/* verif/rsc_supply_pin_model.sv */
// Model of the far side: the reset pin with its weak pull-up and the two supply monitors.
// Assumes the bench commands pin, brown-out and low-supply levels through plain inputs.
module rsc_supply_pin_model (
  input wire logic CLK,
  input wire logic hold_pin_low,
  input wire logic vdd_low,
  input wire logic vdd_low_lp,
  output logic pin_n,
  output logic bod_req,
  output logic lp_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pin is only driven from outside; released it floats up to the pull-up level.
  assign pin_n = hold_pin_low ? 1'b0 : 1'b1;
  always @(posedge CLK) begin
    bod_req <= vdd_low;
    lp_low <= vdd_low_lp;
  end
endmodule

/* verif/tb_reset_source_and_cause_logic.sv */
// Self-checking bench for the reset source and cause logic.
// Assumes APB access with no wait states and a short power-up timer parameter.
module tb_reset_source_and_cause_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned POWERUP_TIMER = 20;
  logic clk = 0;
  logic arst_n = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, dev_rst_n, pc_load, pullup_en;
  logic [1:0] pc_action;
  logic [15:0] pc_target;
  logic [7:0] ev = 8'h00;
  logic sleeping = 0, global_interrupt_enable = 0, hold_low = 0, vlow = 0, vlow_lp = 0;
  logic pin_n, bod_req, lp_low;
  int fails = 0, num_checks = 0, n;
  always #12.5 clk = ~clk;
  rsc_supply_pin_model i_far (.CLK(clk), .hold_pin_low(hold_low), .vdd_low(vlow), .vdd_low_lp(vlow_lp),
    .pin_n(pin_n), .bod_req(bod_req), .lp_low(lp_low));
  rsc_reset_ctrl #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER)) i_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BROWNOUT_DETECT(bod_req), .LOW_POWER_BROWNOUT_DETECT(lp_low), .EXTERNAL_RESET_PIN(pin_n),
    .WATCHDOG_TIMEOUT(ev[0]), .WATCHDOG_WAKE(ev[1]), .INTERRUPT_WAKE(ev[2]), .CLEAR_WATCHDOG_INSTR(ev[3]),
    .RESET_INSTR(ev[4]), .STACK_OVERFLOW(ev[5]), .STACK_UNDERFLOW(ev[6]), .PROGRAM_MODE_EXIT(ev[7]),
    .SLEEPING(sleeping), .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .DEVICE_RESET_N(dev_rst_n), .PC_LOAD(pc_load),
    .PC_ACTION(pc_action), .PC_TARGET(pc_target), .PIN_PULLUP_EN(pullup_en));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(r, exp);
  endtask
  task pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev[i] <= 0;
  endtask
  // Waits for the device reset to fall, then counts the cycles until it rises.
  task cyc;
    n = 0;
    while (dev_rst_n !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (dev_rst_n !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk({pc_load, pc_action, pc_target}, {1'b1, 2'h1, 16'h0000});
  endtask
  task no_rst(input int k);
    repeat (k) @(posedge clk);
    chk(dev_rst_n, 1'b1);
  endtask
  task pin_low(input int k);
    @(posedge clk);
    hold_low <= 1;
    repeat (k) @(posedge clk);
    hold_low <= 0;
  endtask
  initial begin
    #250000;
    fails++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    cyc();
    chk(n >= 10, 1'b1);
    rd(8'h00, 32'h1C);
    rd(8'h04, 32'h18);
    rd(8'h08, 32'h1C);
    rd(8'h0C, 32'h3);
    rd(8'h10, 32'h0);
    chk(pslverr, 1'b1);
    apb(1, 8'h00, 32'hFF);
    rd(8'h00, 32'hDF);
    pulse(4);
    cyc();
    chk(n >= 10, 1'b1);
    rd(8'h00, 32'hDB);
    apb(1, 8'h00, 32'h1F);
    pulse(5);
    cyc();
    rd(8'h00, 32'h9F);
    pulse(6);
    cyc();
    rd(8'h00, 32'hDF);
    apb(1, 8'h08, 32'h0C);
    pulse(6);
    no_rst(20);
    pulse(0);
    cyc();
    rd(8'h00, 32'hCF);
    rd(8'h04, 32'h08);
    pulse(3);
    rd(8'h04, 32'h18);
    pin_low(2);
    no_rst(12);
    pin_low(20);
    cyc();
    chk(n >= 10, 1'b1);
    rd(8'h00, 32'hC7);
    apb(1, 8'h08, 32'h00);
    apb(1, 8'h0C, 32'h0);
    repeat (2) @(posedge clk);
    chk(pullup_en, 1'b0);
    pin_low(20);
    chk(dev_rst_n, 1'b1);
    apb(1, 8'h0C, 32'h1);
    repeat (2) @(posedge clk);
    chk(pullup_en, 1'b1);
    apb(1, 8'h08, 32'h04);
    apb(1, 8'h00, 32'hFF);
    sleeping <= 1;
    pin_low(20);
    sleeping <= 0;
    cyc();
    rd(8'h00, 32'hD7);
    rd(8'h04, 32'h10);
    sleeping <= 1;
    global_interrupt_enable <= 1;
    pulse(2);
    #1 chk({pc_load, pc_action, pc_target}, {1'b1, 2'h3, 16'h0004});
    rd(8'h04, 32'h10);
    global_interrupt_enable <= 0;
    pulse(2);
    #1 chk({pc_load, pc_action}, {1'b1, 2'h2});
    pulse(1);
    #1 chk({pc_load, pc_action}, {1'b1, 2'h2});
    rd(8'h04, 32'h00);
    sleeping <= 0;
    apb(1, 8'h00, 32'hFF);
    vlow_lp <= 1;
    no_rst(10);
    apb(1, 8'h08, 32'h05);
    repeat (6) @(posedge clk);
    vlow_lp <= 0;
    cyc();
    rd(8'h00, 32'h1E);
    apb(1, 8'h08, 32'h06);
    apb(1, 8'h00, 32'hFF);
    vlow <= 1;
    repeat (5) @(posedge clk);
    vlow <= 0;
    cyc();
    chk(n >= POWERUP_TIMER + 10, 1'b1);
    rd(8'h00, 32'h1E);
    rd(8'h04, 32'h18);
    apb(1, 8'h00, 32'hFF);
    pulse(7);
    cyc();
    rd(8'h00, 32'h1C);
    rd(8'h04, 32'h18);
    wrap_up;
  end
endmodule
